// file: core/lxs_pkg.sv
// Shared constants, register map and carrier types of the laser sequencer
package lxs_pkg;
  // Clock and timebase
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned TICK_NS = 100_000;
  localparam int unsigned TICK_CYC = TICK_NS / CLK_PERIOD_NS;
  localparam int unsigned TICKS_PER_MS = 1_000_000 / TICK_NS;
  // Sequence times in their own units, then in ticks or cycles
  localparam int unsigned DIODE_UP_MS = 5000;
  localparam int unsigned PREP_MS = 1000;
  localparam int unsigned HEAT_MS = 200;
  localparam int unsigned PRELIM_DLY_NS = 75_000;
  localparam int unsigned PRELIM_US = 500;
  localparam int unsigned ERR_MIN_MS = 1;
  localparam logic [15:0] DIODE_UP_TICKS = 16'(DIODE_UP_MS * TICKS_PER_MS);
  localparam logic [15:0] PREP_TICKS = 16'(PREP_MS * TICKS_PER_MS);
  localparam logic [15:0] HEAT_TICKS = 16'(HEAT_MS * TICKS_PER_MS);
  localparam logic [11:0] PRELIM_DLY_CYC = 12'(PRELIM_DLY_NS / CLK_PERIOD_NS);
  localparam logic [15:0] PRELIM_TICKS = 16'(PRELIM_US * 1000 / TICK_NS);
  localparam logic [15:0] ERR_MIN_TICKS = 16'(ERR_MIN_MS * TICKS_PER_MS);
  // Acceptance times in ticks of 0.1 ms
  localparam logic [15:0] ACC_0P1_TICKS = 16'h0001;
  localparam logic [15:0] ACC_1_TICKS = 16'h000a;
  localparam logic [15:0] ACC_2_TICKS = 16'h0014;
  localparam logic [15:0] ACC_4_TICKS = 16'h0028;
  localparam logic [15:0] ACC_8_TICKS = 16'h0050;
  localparam logic [15:0] ACC_16_TICKS = 16'h00a0;
  // Output pulse widths in ticks
  localparam logic [15:0] PW_20_TICKS = 16'h00c8;
  localparam logic [15:0] PW_30_TICKS = 16'h012c;
  localparam logic [15:0] PW_40_TICKS = 16'h0190;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CFG = 8'h04;
  localparam logic [7:0] OFS_LIMIT = 8'h08;
  localparam logic [7:0] OFS_COOL = 8'h0c;
  localparam logic [7:0] OFS_BEAMW = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam logic [7:0] OFS_ENERGY = 8'h18;
  // Field positions
  localparam int unsigned CTRL_DIODE_REQ_BIT = 0;
  localparam int unsigned STAT_READY_BIT = 9;
  localparam int unsigned STAT_EXT_BIT = 10;
  localparam int unsigned STAT_SCHED_LSB = 16;
  // Reset values
  localparam logic [8:0] CFG_RST = 9'h000;
  localparam logic [15:0] LIMIT_HI_RST = 16'hffff;
  localparam logic [15:0] LIMIT_LO_RST = 16'h0000;
  localparam logic [15:0] COOL_RST = 16'h000a;
  localparam logic [15:0] BEAMW_RST = 16'h000a;
  // Configuration carrier, bit order as in the CFG register
  typedef struct packed {
    logic heat_en;
    logic ts_en;
    logic fast_rep;
    logic repeat_en;
    logic [1:0] pw_sel;
    logic [2:0] acc_sel;
  } lxs_cfg_t;
  // Judgement carrier handed to the hold stage
  typedef struct packed {
    logic mon_err;
    logic lo;
    logic hi;
    logic ok;
    logic done;
  } lxs_judge_t;
  // Filtered schedule inputs: beam select, heat detector setting, schedule number
  typedef struct packed {
    logic [1:0] beam;
    logic heat;
    logic [4:0] num;
  } lxs_sched_t;
endpackage : lxs_pkg

// file: core/lxs_accept.sv
// Two-flop synchroniser and stable-time acceptance filter for contact inputs
`timescale 1ns/10ps
module lxs_accept #(
  parameter int unsigned W = 1
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic reset_n_i,
  // Timebase and acceptance time
  input wire logic tick_i,
  input wire logic [15:0] acc_ticks_i,
  // Raw contacts and accepted value
  input wire logic [W-1:0] raw_i,
  output logic [W-1:0] val_o,
  output logic chg_o
);
  logic [W-1:0] sync1_q;
  logic [W-1:0] sync2_q;
  logic [W-1:0] cand_q;
  logic [15:0] cnt_q;

  // First stage feeds only the second
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= raw_i;
      sync2_q <= sync1_q;
    end
  end

  // Any change restarts the stability count
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cand_q <= '0;
      cnt_q <= 16'h0000;
    end else if (sync2_q != cand_q) begin
      cand_q <= sync2_q;
      cnt_q <= 16'h0000;
    end else if (tick_i && cnt_q != 16'hffff) begin
      cnt_q <= cnt_q + 16'h0001;
    end
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      val_o <= '0;
      chg_o <= 1'b0;
    end else begin
      chg_o <= 1'b0;
      if (sync2_q == cand_q && cand_q != val_o && cnt_q >= acc_ticks_i) begin
        val_o <= cand_q;
        chg_o <= 1'b1;
      end
    end
  end
endmodule : lxs_accept

// file: core/lxs_hold.sv
// Holds a group of output flags for a number of timebase ticks
`timescale 1ns/10ps
module lxs_hold #(
  parameter int unsigned W = 5
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic reset_n_i,
  // Timebase
  input wire logic tick_i,
  // Load request
  input wire logic load_i,
  input wire logic [15:0] len_i,
  input wire logic [W-1:0] data_i,
  // Held flags
  output logic [W-1:0] data_o
);
  logic [15:0] cnt_q;

  // A new load restarts the width, so back-to-back results are never merged
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cnt_q <= 16'h0000;
      data_o <= '0;
    end else if (load_i) begin
      cnt_q <= len_i;
      data_o <= data_i;
    end else if (cnt_q == 16'h0000) begin
      data_o <= '0;
    end else if (tick_i) begin
      cnt_q <= cnt_q - 16'h0001;
    end
  end
endmodule : lxs_hold

// file: core/lxs_seq.sv
// Emission sequencer with contact inputs, judgement outputs and APB registers
//
// The register offsets and the APB interface to the registers were left to the implementer.
`timescale 1ns/10ps

// What this block does
// - Mode contact open selects front_console_source, closed selects external inputs.
// - Panel: one button press starts emission, the next press ends it.
// - External: start closes with permit closed emits; permit opening halts at once.
// - Pump diode power-up completes within its bounded time before anything proceeds.
// - Output preparation finishes and ready rises within a bounded time.
// - Repeat mode keeps ready low for a cooldown after each emission.
// - Ready stays low until a valid schedule is selected.
// - Schedule and start are accepted only after stable for the acceptance time.
// - Heat control on and heat setting changed adds about 200 ms.
// - Preliminary oscillation starts 50 to 100 us after start acceptance.
// - Programmed waveform starts 0.5 ms after the preliminary oscillation.
// - End-of-emission output is asserted after each emission.
// - Judgement shows energy within limits, above upper or below lower.
// - End and judgement outputs hold for 20, 30 or 40 ms, or for 1 ms when fast repeat is set.
// - Timesharing emits on branch 1 or 2 as the beam select chooses.
// - Beam changeover wait only when beam select differs from the previous.
// - At 50 pps or more the monitor error holds at least 1 ms.
module lxs_seq
  import lxs_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = lxs_pkg::TICK_CYC,
  parameter logic [15:0] DIODE_UP_T = lxs_pkg::DIODE_UP_TICKS,
  parameter logic [15:0] PREP_T = lxs_pkg::PREP_TICKS,
  parameter logic [15:0] HEAT_T = lxs_pkg::HEAT_TICKS
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic reset_n_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Contacts of user_connector_one and the panel
  input wire logic ext_mode_i,
  input wire logic front_console_btn_i,
  input wire logic start_req_i,
  input wire logic permit_i,
  input wire lxs_pkg::lxs_sched_t sched_i,
  // Waveform generator and energy monitor
  input wire logic wave_done_i,
  input wire logic energy_vld_i,
  input wire logic [15:0] energy_i,
  // Sequence outputs
  output logic pump_diode_on_o,
  output logic ready_o,
  output logic prelim_o,
  output logic wave_go_o,
  output logic [1:0] branch_o,
  output lxs_pkg::lxs_judge_t judge_o
);
  import lxs_pkg::*;

  typedef enum logic [8:0] {
    ST_OFF = 9'h001,
    ST_PWRUP = 9'h002,
    ST_PREP = 9'h004,
    ST_READY = 9'h008,
    ST_BEAMW = 9'h010,
    ST_DLY = 9'h020,
    ST_PRE = 9'h040,
    ST_EMIT = 9'h080,
    ST_COOL = 9'h100
  } lxs_state_t;

  function automatic logic [15:0] acc_ticks(input logic [2:0] sel);
    case (sel)
      3'h1: acc_ticks = ACC_0P1_TICKS;
      3'h2: acc_ticks = ACC_1_TICKS;
      3'h3: acc_ticks = ACC_2_TICKS;
      3'h4: acc_ticks = ACC_8_TICKS;
      3'h5: acc_ticks = ACC_16_TICKS;
      default: acc_ticks = ACC_4_TICKS;
    endcase
  endfunction : acc_ticks

  function automatic logic [15:0] pw_ticks(input logic [1:0] sel);
    case (sel)
      2'h1: pw_ticks = PW_30_TICKS;
      2'h2: pw_ticks = PW_40_TICKS;
      default: pw_ticks = PW_20_TICKS;
    endcase
  endfunction : pw_ticks

  lxs_state_t state_q;
  lxs_cfg_t cfg_q;
  logic diode_req_q;
  logic [15:0] lim_hi_q;
  logic [15:0] lim_lo_q;
  logic [15:0] cool_q;
  logic [15:0] beamw_q;
  logic [15:0] energy_q;
  logic [11:0] tick_cnt_q;
  logic tick_q;
  logic [15:0] wait_q;
  logic [11:0] dly_q;
  logic [1:0] last_beam_q;
  logic last_beam_vld_q;
  logic heat_last_q;
  logic sched_ok_q;
  logic mode_sync1_q;
  logic ext_mode_q;
  logic permit_sync1_q;
  logic permit_q;
  logic start_acc;
  logic start_chg;
  logic btn_acc;
  logic btn_chg;
  logic sched_chg;
  lxs_sched_t sched_acc;
  logic [15:0] acc_t;
  logic go_req;
  logic stop_req;
  logic end_load;
  lxs_judge_t judge_d;
  logic [15:0] hold_len;
  logic apb_wr;

  assign acc_t = acc_ticks(cfg_q.acc_sel);
  assign apb_wr = psel_i && penable_i && pready_o && pwrite_i;

  // Timebase of 0.1 ms ticks
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tick_cnt_q <= 12'h000;
      tick_q <= 1'b0;
    end else begin
      tick_q <= (tick_cnt_q == 12'(TICK_CYCLES - 1));
      tick_cnt_q <= (tick_cnt_q == 12'(TICK_CYCLES - 1)) ? 12'h000 : tick_cnt_q + 12'h001;
    end
  end

  // Mode and permit only synchronised: permit must halt without filter delay
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      mode_sync1_q <= 1'b0;
      ext_mode_q <= 1'b0;
      permit_sync1_q <= 1'b0;
      permit_q <= 1'b0;
    end else begin
      mode_sync1_q <= ext_mode_i;
      ext_mode_q <= mode_sync1_q;
      permit_sync1_q <= permit_i;
      permit_q <= permit_sync1_q;
    end
  end

  lxs_accept #(.W(1)) u_start (
    .mclk_i(mclk_i),
    .reset_n_i(reset_n_i),
    .tick_i(tick_q),
    .acc_ticks_i(acc_t),
    .raw_i(start_req_i),
    .val_o(start_acc),
    .chg_o(start_chg)
  );

  lxs_accept #(.W(1)) u_button (
    .mclk_i(mclk_i),
    .reset_n_i(reset_n_i),
    .tick_i(tick_q),
    .acc_ticks_i(acc_t),
    .raw_i(front_console_btn_i),
    .val_o(btn_acc),
    .chg_o(btn_chg)
  );

  lxs_accept #(.W(8)) u_sched (
    .mclk_i(mclk_i),
    .reset_n_i(reset_n_i),
    .tick_i(tick_q),
    .acc_ticks_i(acc_t),
    .raw_i(sched_i),
    .val_o(sched_acc),
    .chg_o(sched_chg)
  );

  // Panel presses count only under front_console_source, start and permit contacts only under external
  assign go_req = ext_mode_q ? (start_chg && start_acc && permit_q)
                             : (btn_chg && btn_acc);
  assign stop_req = ext_mode_q ? !permit_q : (btn_chg && btn_acc);

  // Schedule becomes valid after acceptance, plus heat settle when needed
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sched_ok_q <= 1'b0;
      heat_last_q <= 1'b0;
    end else if (sched_chg) begin
      heat_last_q <= sched_acc.heat;
      sched_ok_q <= (sched_acc.num != 5'h00) &&
                    !(cfg_q.heat_en && sched_acc.heat != heat_last_q);
    end else if (state_q == ST_READY && wait_q == 16'h0000 && sched_acc.num != 5'h00) begin
      sched_ok_q <= 1'b1;
    end
  end

  // Main sequence and its wait counters
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_q <= ST_OFF;
      wait_q <= 16'h0000;
      dly_q <= 12'h000;
      last_beam_q <= 2'h0;
      last_beam_vld_q <= 1'b0;
    end else if (!diode_req_q) begin
      state_q <= ST_OFF;
      wait_q <= 16'h0000;
    end else begin
      if (tick_q && wait_q != 16'h0000) begin
        wait_q <= wait_q - 16'h0001;
      end
      if (sched_chg && cfg_q.heat_en && sched_acc.heat != heat_last_q) begin
        wait_q <= HEAT_T;
      end
      case (state_q)
        ST_OFF: begin
          state_q <= ST_PWRUP;
          wait_q <= DIODE_UP_T;
        end
        ST_PWRUP: begin
          if (wait_q == 16'h0000) begin
            state_q <= ST_PREP;
            wait_q <= PREP_T;
          end
        end
        ST_PREP: begin
          if (wait_q == 16'h0000) begin
            state_q <= ST_READY;
          end
        end
        ST_READY: begin
          // Starts outside ready are ignored; the controller waits for ready
          if (go_req && sched_ok_q) begin
            if (cfg_q.ts_en && last_beam_vld_q && sched_acc.beam != last_beam_q) begin
              state_q <= ST_BEAMW;
              wait_q <= beamw_q;
            end else begin
              state_q <= ST_DLY;
              dly_q <= PRELIM_DLY_CYC;
            end
            last_beam_q <= sched_acc.beam;
            last_beam_vld_q <= 1'b1;
          end
        end
        ST_BEAMW: begin
          if (ext_mode_q && !permit_q) begin
            state_q <= ST_READY;
          end else if (wait_q == 16'h0000) begin
            state_q <= ST_DLY;
            dly_q <= PRELIM_DLY_CYC;
          end
        end
        ST_DLY: begin
          if (ext_mode_q && !permit_q) begin
            state_q <= ST_READY;
          end else if (dly_q == 12'h001) begin
            state_q <= ST_PRE;
            wait_q <= PRELIM_TICKS;
          end else begin
            dly_q <= dly_q - 12'h001;
          end
        end
        ST_PRE: begin
          if (ext_mode_q && !permit_q) begin
            state_q <= ST_READY;
          end else if (wait_q == 16'h0000) begin
            state_q <= ST_EMIT;
          end
        end
        ST_EMIT: begin
          if (wave_done_i || stop_req) begin
            state_q <= cfg_q.repeat_en ? ST_COOL : ST_PREP;
            wait_q <= cfg_q.repeat_en ? cool_q : PREP_T;
          end
        end
        ST_COOL: begin
          if (wait_q == 16'h0000) begin
            state_q <= ST_READY;
          end
        end
        default: begin
          state_q <= ST_OFF;
        end
      endcase
    end
  end

  // Sequence outputs, each from its own flop
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pump_diode_on_o <= 1'b0;
      ready_o <= 1'b0;
      prelim_o <= 1'b0;
      wave_go_o <= 1'b0;
      branch_o <= 2'h0;
    end else begin
      pump_diode_on_o <= diode_req_q;
      ready_o <= (state_q == ST_READY) && sched_ok_q;
      prelim_o <= (state_q == ST_PRE);
      wave_go_o <= (state_q == ST_EMIT) && !(wave_done_i || stop_req);
      if (state_q == ST_DLY) begin
        branch_o <= cfg_q.ts_en ? sched_acc.beam : 2'h1;
      end
    end
  end

  // Energy of the running emission
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      energy_q <= 16'h0000;
    end else if (energy_vld_i && state_q == ST_EMIT) begin
      energy_q <= energy_i;
    end
  end

  assign end_load = (state_q == ST_EMIT) && (wave_done_i || stop_req);
  always_comb begin
    judge_d.done = 1'b1;
    judge_d.hi = energy_q > lim_hi_q;
    judge_d.lo = energy_q < lim_lo_q;
    judge_d.ok = !judge_d.hi && !judge_d.lo;
    judge_d.mon_err = judge_d.hi || judge_d.lo;
  end
  // Fast repeat shortens the hold so the next result is not masked
  assign hold_len = cfg_q.fast_rep ? ERR_MIN_TICKS : pw_ticks(cfg_q.pw_sel);

  lxs_hold #(.W(5)) u_hold (
    .mclk_i(mclk_i),
    .reset_n_i(reset_n_i),
    .tick_i(tick_q),
    .load_i(end_load),
    .len_i(hold_len),
    .data_i(judge_d),
    .data_o(judge_o)
  );

  // Register writes
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      diode_req_q <= 1'b0;
      cfg_q <= CFG_RST;
      lim_hi_q <= LIMIT_HI_RST;
      lim_lo_q <= LIMIT_LO_RST;
      cool_q <= COOL_RST;
      beamw_q <= BEAMW_RST;
    end else if (apb_wr) begin
      case (paddr_i)
        OFS_CTRL: diode_req_q <= pwdata_i[CTRL_DIODE_REQ_BIT];
        OFS_CFG: cfg_q <= pwdata_i[8:0];
        OFS_LIMIT: begin
          lim_lo_q <= pwdata_i[15:0];
          lim_hi_q <= pwdata_i[31:16];
        end
        OFS_COOL: cool_q <= pwdata_i[15:0];
        OFS_BEAMW: beamw_q <= pwdata_i[15:0];
        default: ;
      endcase
    end
  end

  // Answer prepared in the setup cycle, so every access takes one wait-free cycle
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h0000_0000;
    end else begin
      pready_o <= psel_i && !penable_i;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h0000_0000;
      if (psel_i && !penable_i) begin
        case (paddr_i)
          OFS_CTRL: prdata_o <= {31'h0000_0000, diode_req_q};
          OFS_CFG: prdata_o <= {23'h00_0000, cfg_q};
          OFS_LIMIT: prdata_o <= {lim_hi_q, lim_lo_q};
          OFS_COOL: prdata_o <= {16'h0000, cool_q};
          OFS_BEAMW: prdata_o <= {16'h0000, beamw_q};
          OFS_STATUS: prdata_o <= {8'h00, sched_acc, 5'h00, ext_mode_q, ready_o, state_q};
          OFS_ENERGY: prdata_o <= {16'h0000, energy_q};
          default: pslverr_o <= 1'b1;
        endcase
      end
    end
  end
endmodule : lxs_seq

// file: tb/lxs_seq_properties.sv
// Port-level checks on the laser sequencer
`timescale 1ns/10ps
module lxs_seq_properties
  import lxs_pkg::*;
(
  // Clock, reset and APB
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pready_o,
  input wire logic pslverr_o,
  // Sequence
  input wire logic ext_mode_i,
  input wire logic permit_i,
  input wire logic wave_done_i,
  input wire logic ready_o,
  input wire logic prelim_o,
  input wire logic wave_go_o,
  input wire logic [1:0] branch_o,
  input wire lxs_pkg::lxs_judge_t judge_o
);
  logic [15:0] idle_q;
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!reset_n_i);
  // Cycles since ready last stood high, saturating
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i)
      idle_q <= 16'h0000;
    else
      idle_q <= ready_o ? 16'h0000 : idle_q + {15'h0000, idle_q != 16'hffff};
  end
  sequence s_setup;
    psel_i && !penable_i;
  endsequence
  sequence s_wave_end;
    wave_go_o && wave_done_i;
  endsequence
  a_apb_answer: assert property (s_setup |=> pready_o)
    else $error("pready missing after setup");
  a_err_qualified: assert property (pslverr_o |-> pready_o)
    else $error("pslverr without pready");
  a_prelim_delay: assert property ($rose(prelim_o) |->
    idle_q >= 16'h07d0 && idle_q <= 16'h0fa0)
    else $error("preliminary start outside 50 to 100 us");
  a_wave_after_pre: assert property ($rose(wave_go_o) |-> $past(prelim_o))
    else $error("waveform without preliminary phase");
  a_permit_halt: assert property ((ext_mode_i && !permit_i) [*6] |->
    !wave_go_o && !prelim_o)
    else $error("emission with permit open");
  a_end_pulse: assert property (s_wave_end |-> ##[1:4] judge_o.done)
    else $error("no end output after emission");
  a_wave_stop: assert property (s_wave_end |-> ##[1:4] !wave_go_o)
    else $error("waveform kept after completion");
  a_judge_excl: assert property (judge_o.done |->
    judge_o.ok ^ (judge_o.hi | judge_o.lo))
    else $error("judgement flags inconsistent");
  a_judge_hold: assert property ($rose(judge_o.done) |-> judge_o.done [*8])
    else $error("end output too short");
  a_branch_legal: assert property (wave_go_o |->
    branch_o != 2'h0 && branch_o != 2'h3)
    else $error("no single branch during emission");
  a_ready_idle: assert property (ready_o |-> !prelim_o && !wave_go_o)
    else $error("ready during emission");
endmodule : lxs_seq_properties

// file: tb/lxs_plc_model.sv
// Behavioural controller on the external connector
`timescale 1ns/10ps
module lxs_plc_model (
  // Clock and device status
  input wire logic mclk_i,
  input wire logic ready_i,
  // Commands from the bench
  input wire logic fire_i,
  input wire logic abort_i,
  input wire logic [15:0] hold_i,
  // Contacts toward the device
  output logic start_o,
  output logic permit_o
);
  logic arm_q;
  logic [15:0] cnt_q;
  initial begin
    arm_q = 1'b0;
    start_o = 1'b0;
    cnt_q = 16'h0000;
  end
  // Start stays open until ready is seen closed
  always @(posedge mclk_i) begin
    if (fire_i) begin
      arm_q <= 1'b1;
    end else if (arm_q && ready_i) begin
      arm_q <= 1'b0;
      start_o <= 1'b1;
      cnt_q <= hold_i;
    end else if (start_o) begin
      cnt_q <= cnt_q - 16'h0001;
      start_o <= cnt_q != 16'h0001;
    end
  end
  assign permit_o = !abort_i;
endmodule : lxs_plc_model

// file: tb/tb.sv
// Self-checking bench for the laser sequencer
`timescale 1ns/10ps
module tb;
  import lxs_pkg::*;
  localparam int unsigned T = 4;
  logic mclk_i, reset_n_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o, er;
  logic ext_mode_i, front_console_btn_i, start_req_i, permit_i, wave_done_i, energy_vld_i;
  logic pump_diode_on_o, ready_o, prelim_o, wave_go_o, fire, abort;
  logic [7:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o, rd;
  logic [15:0] energy_i, hold, e;
  logic [1:0] branch_o;
  lxs_sched_t sched_i;
  lxs_judge_t judge_o;
  int n_errors, checked, wn, n, seed;
  logic [7:0] ra [6] = '{OFS_CTRL, OFS_CFG, OFS_LIMIT, OFS_COOL, OFS_BEAMW, 8'h40};
  logic [31:0] rv [6] = '{32'h0, 32'(CFG_RST), {LIMIT_HI_RST, LIMIT_LO_RST}, 32'(COOL_RST),
    32'(BEAMW_RST), 32'h0};
  logic [15:0] pwt [4] = '{PW_20_TICKS, PW_30_TICKS, PW_40_TICKS, ERR_MIN_TICKS};
  logic [15:0] eb [4] = '{16'h2000, 16'h9000, 16'h0000, 16'h9000};

  lxs_seq #(.TICK_CYCLES(T), .DIODE_UP_T(16'h0003), .PREP_T(16'h0003), .HEAT_T(16'h0003))
  u_lxs_seq (.mclk_i, .reset_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
    .prdata_o, .pready_o, .pslverr_o, .ext_mode_i, .front_console_btn_i, .start_req_i,
    .permit_i, .sched_i, .wave_done_i, .energy_vld_i, .energy_i, .pump_diode_on_o,
    .ready_o, .prelim_o, .wave_go_o, .branch_o, .judge_o);
  lxs_plc_model u_lxs_plc_model (.mclk_i, .ready_i(ready_o), .fire_i(fire),
    .abort_i(abort), .hold_i(hold), .start_o(start_req_i), .permit_o(permit_i));

  initial begin
    mclk_i = 1'b0;
    forever #12.5 mclk_i = ~mclk_i;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic summarize();
    $display("checked %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : summarize

  function automatic logic sg(input int s);
    case (s)
      0: return ready_o;
      1: return prelim_o;
      2: return wave_go_o;
      default: return judge_o.done;
    endcase
  endfunction : sg

  // Limits are written as lo 1000, hi 8000
  function automatic logic [4:0] jf(input logic [15:0] x);
    return {x < 16'h1000 || x > 16'h8000, x < 16'h1000, x > 16'h8000,
      x >= 16'h1000 && x <= 16'h8000, 1'b1};
  endfunction : jf

  // Bounded wait; wn holds the cycles spent
  task automatic wt(input int s, input logic v, input int lim);
    wn = 0;
    do begin
      @(negedge mclk_i);
      wn++;
    end while (sg(s) !== v && wn < lim);
    if (sg(s) !== v) begin
      chk(sg(s), v);
      summarize();
    end
  endtask : wt

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge mclk_i);
    penable_i <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 20);
    rd = prdata_o;
    er = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    if (n == 20) begin
      chk(pready_o, 1'b1);
      summarize();
    end
  endtask : apb

  task automatic go(input logic [15:0] h);
    @(posedge mclk_i);
    hold <= h;
    fire <= 1'b1;
    @(posedge mclk_i);
    fire <= 1'b0;
  endtask : go

  task automatic press();
    @(posedge mclk_i);
    front_console_btn_i <= 1'b1;
    repeat (300) @(posedge mclk_i);
    front_console_btn_i <= 1'b0;
  endtask : press

  task automatic shot(input logic [15:0] x, input int pw);
    go(16'h0190);
    wt(1, 1'b1, 6000);
    wt(2, 1'b1, 40);
    chk(wn + T >= PRELIM_TICKS * T && wn <= (PRELIM_TICKS + 1) * T, 1'b1);
    @(posedge mclk_i);
    energy_vld_i <= 1'b1;
    energy_i <= x;
    @(posedge mclk_i);
    energy_vld_i <= 1'b0;
    wave_done_i <= 1'b1;
    @(posedge mclk_i);
    wave_done_i <= 1'b0;
    wt(3, 1'b1, 8);
    chk(judge_o, jf(x));
    wt(3, 1'b0, pw + 2 * T);
    chk(wn + T >= pw && wn <= pw + T, 1'b1);
  endtask : shot

  initial begin
    seed = 32'hd320;
    n_errors = 0;
    checked = 0;
    reset_n_i = 1'b0;
    psel_i = 1'b0;
    penable_i = 1'b0;
    pwrite_i = 1'b0;
    paddr_i = 8'h00;
    pwdata_i = 32'h0;
    ext_mode_i = 1'b1;
    front_console_btn_i = 1'b0;
    sched_i = '0;
    wave_done_i = 1'b0;
    energy_vld_i = 1'b0;
    energy_i = 16'h0000;
    fire = 1'b0;
    abort = 1'b0;
    hold = 16'h0190;
    repeat (10) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, ra[i], 32'h0);
      chk(rd, rv[i]);
      chk(er, i == 5);
    end
    $display("register test done");
    apb(1'b1, OFS_LIMIT, 32'h80001000);
    apb(1'b1, OFS_CTRL, 32'h1);
    repeat (2) @(negedge mclk_i);
    chk(pump_diode_on_o, 1'b1);
    repeat (400) @(negedge mclk_i);
    chk(ready_o, 1'b0);
    @(posedge mclk_i);
    sched_i <= '{beam: 2'h1, heat: 1'b0, num: 5'h01 | 5'($random(seed))};
    wt(0, 1'b1, 2000);
    // Closure shorter than the 4 ms acceptance time
    go(16'h0064);
    repeat (600) @(negedge mclk_i);
    chk(ready_o, 1'b1);
    $display("power-up and filter test done");
    // Last pass: repeat, fast repeat and timesharing with a beam change
    apb(1'b1, OFS_COOL, 32'h0000_0100);
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, OFS_CFG, (i < 3) ? 32'(i << 3) : 32'h0000_00e0);
      if (i == 3)
        sched_i.beam <= 2'h2;
      e = eb[i] + {4'h0, 12'($random(seed))};
      shot(e, int'(pwt[i]) * T);
      if (i == 3) begin
        chk(branch_o, 2'h2);
        chk(ready_o, 1'b0);
      end
      wt(0, 1'b1, 2000);
      if (i == 3)
        chk(wn > 900, 1'b1);
    end
    $display("emission test done");
    go(16'h0190);
    wt(2, 1'b1, 6000);
    @(posedge mclk_i);
    abort <= 1'b1;
    wt(2, 1'b0, 8);
    chk(wave_go_o, 1'b0);
    @(posedge mclk_i);
    abort <= 1'b0;
    wt(0, 1'b1, 2000);
    $display("permit test done");
    @(posedge mclk_i);
    ext_mode_i <= 1'b0;
    go(16'h0190);
    repeat (3600) @(negedge mclk_i);
    chk(prelim_o, 1'b0);
    chk(ready_o, 1'b1);
    press();
    wt(2, 1'b1, 6000);
    press();
    wt(2, 1'b0, 400);
    chk(wave_go_o, 1'b0);
    $display("panel test done");
    summarize();
  end
endmodule : tb

bind lxs_seq lxs_seq_properties u_lxs_seq_properties (.mclk_i, .reset_n_i, .psel_i,
  .penable_i, .pready_o, .pslverr_o, .ext_mode_i, .permit_i, .wave_done_i, .ready_o,
  .prelim_o, .wave_go_o, .branch_o, .judge_o);
